//--- hw/adc_sequencer_control.sv
// Control logic of a 10-bit successive-approximation converter, APB slave.
// Assumes an analog front end that answers compareHigh each bit period and
// trigger sources that are synchronous to clk or pass the pin synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"

// Functional notes
// - Writing go bit starts; clears on finish
// - Enable bit powers converter, else off
// - Top channel codes route internal sources
// - Port channel codes; reserved connect nothing
// - Format one: right justified, zero upper
// - Format zero: left justified, zero lower
// - Clock field picks divisor or RC
// - Negative reference ground or external pin
// - Enable zero disconnects every mux input
// - Positive reference field selects source
// - Trigger field maps to seventeen sources
// - Triggers act on rising edge only
// - Timer triggers coincide with flag set
// - Unimplemented bits read zero, ignore writes
// - Completion clears go, flags, loads result
// - Early clear stores partial, fills bits
// - Full conversion takes twelve bit periods
// - Trigger edge sets go by hardware
module adc_sequencer_control
    import adc_seq_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Trigger sources, index equals trigger code
    input  wire logic [17:0] triggerSources,
    // Dedicated RC oscillator tick, from its own domain
    input  wire logic        rcTickPin,
    // Comparator decision of the analog front end
    input  wire logic        compareHigh,
    // Analog controls and status
    output analog_ctl_t      analogCtl,
    output logic             conversionBusy,
    output logic             completionFlag
);

    typedef struct packed {
        logic [5:0]  channel;
        logic        go;
        logic        enable;
        logic [7:0]  ctrl1;
        logic [4:0]  trigSel;
        logic [9:0]  result;
        logic        resultFormat;
        logic        complete;
        logic        trigPrev;
        logic [2:0]  rcSync;
        logic [6:0]  divCnt;
        logic [3:0]  period;
        logic [9:0]  sar;
        logic        lastBit;
        conv_state_t state;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        analog_ctl_t analogCtl;
    } state_t;

    state_t cur_ff;
    state_t nxt_ff;

    // Channel legality: reserved codes connect nothing
    function automatic logic channelValid(input logic [5:0] ch);
        channelValid = (ch <= `CH_PORTA_LAST && ch != `CH_PORTA_HOLE) ||
                       (ch >= `CH_PORTB_FIRST && ch <= `CH_PORTC_LAST) ||
                       (ch >= `CH_GROUND);
    endfunction : channelValid

    // Divider terminal count for the clock field, minus one
    function automatic logic [6:0] divLimit(input logic [2:0] sel);
        unique case (sel)
            3'h0:    divLimit = 7'h01;
            3'h1:    divLimit = 7'h07;
            3'h2:    divLimit = 7'h1F;
            3'h4:    divLimit = 7'h03;
            3'h5:    divLimit = 7'h0F;
            3'h6:    divLimit = 7'h3F;
            default: divLimit = 7'h00;   // RC codes 011 and 111
        endcase
    endfunction : divLimit

    logic       useRc;
    logic       rcTick;
    logic       tadTick;
    logic       trigNow;
    logic       wrEn;
    logic [9:0] storeVal;

    // Clock-source selection and bit-period tick
    always_comb begin
        useRc   = (cur_ff.ctrl1[5:4] == 2'h3);
        rcTick  = cur_ff.rcSync[2] ^ cur_ff.rcSync[1];               // Toggle edge after agreement
        tadTick = useRc ? rcTick : (cur_ff.divCnt == divLimit(cur_ff.ctrl1[6:4]));
        trigNow = (cur_ff.trigSel != `TRIG_NONE) && (cur_ff.trigSel <= `TRIG_LAST)
                  ? triggerSources[cur_ff.trigSel] : 1'b0;
        wrEn    = psel && penable && pwrite && !cur_ff.pready;
        // Unconverted bits copy the last decided bit
        storeVal = cur_ff.sar;
        for (int i = 0; i < 10; i++) begin
            if (i < 10 - cur_ff.period + 2 && cur_ff.period > 4'h1)
                storeVal[i] = cur_ff.lastBit;
        end
    end

    // Next-state logic: bus, sequencer and result
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.rcSync  = {cur_ff.rcSync[1:0], rcTickPin};
        nxt_ff.trigPrev = trigNow;
        nxt_ff.pready  = 1'b0;
        nxt_ff.pslverr = 1'b0;
        nxt_ff.divCnt  = tadTick || useRc ? 7'h00 : cur_ff.divCnt + 7'h01;

        // Register writes
        if (wrEn) begin
            unique case (paddr)
                `ADDR_CTRL0: begin
                    nxt_ff.channel = pwdata[7:2];
                    nxt_ff.enable  = pwdata[`CTRL0_ENABLE_BIT];
                    nxt_ff.go      = pwdata[`CTRL0_GO_BIT] && pwdata[`CTRL0_ENABLE_BIT];
                end
                `ADDR_CTRL1: nxt_ff.ctrl1   = pwdata[7:0] & `CTRL1_MASK;
                `ADDR_TRIG:  nxt_ff.trigSel = pwdata[4:0];
                `ADDR_COMPLETE: if (!pwdata[0]) nxt_ff.complete = 1'b0;
                default: ;
            endcase
        end

        // Hardware trigger on rising edge only
        if (trigNow && !cur_ff.trigPrev && nxt_ff.enable)
            nxt_ff.go = 1'b1;

        unique case (cur_ff.state)
            ST_IDLE: begin
                if (nxt_ff.go) begin
                    nxt_ff.state  = ST_CONVERT;
                    nxt_ff.period = 4'h0;
                    nxt_ff.sar    = 10'h000;
                    // Stale bit of an earlier conversion must not fill an early abort
                    nxt_ff.lastBit = 1'b0;
                    nxt_ff.divCnt = 7'h00;
                end
            end
            ST_CONVERT: begin
                if (!nxt_ff.go || !nxt_ff.enable) begin
                    // Abort: keep partial result with filled tail
                    nxt_ff.result       = storeVal;
                    nxt_ff.resultFormat = cur_ff.ctrl1[7];
                    nxt_ff.go           = 1'b0;
                    nxt_ff.state        = ST_IDLE;
                end else if (tadTick) begin
                    nxt_ff.period = cur_ff.period + 4'h1;
                    if (cur_ff.period >= 4'h2 && cur_ff.period < `CONV_PERIODS) begin
                        nxt_ff.sar[4'hB - cur_ff.period] = compareHigh;
                        nxt_ff.lastBit = compareHigh;
                    end
                    if (cur_ff.period == `CONV_PERIODS - 4'h1) begin
                        nxt_ff.sar[0]       = compareHigh;
                        nxt_ff.result       = {cur_ff.sar[9:1], compareHigh};
                        nxt_ff.resultFormat = cur_ff.ctrl1[7];
                        nxt_ff.go           = 1'b0;
                        nxt_ff.complete     = 1'b1;
                        nxt_ff.state        = ST_IDLE;
                    end
                end
            end
        endcase

        // Register reads and APB answer after one wait state
        if (psel && penable && !cur_ff.pready) begin
            nxt_ff.pready = 1'b1;
            nxt_ff.prdata = 32'h0000_0000;
            unique case (paddr)
                `ADDR_CTRL0:   nxt_ff.prdata[7:0] = {cur_ff.channel, cur_ff.go, cur_ff.enable};
                `ADDR_CTRL1:   nxt_ff.prdata[7:0] = cur_ff.ctrl1;
                `ADDR_TRIG:    nxt_ff.prdata[7:0] = {3'h0, cur_ff.trigSel};
                `ADDR_RES_UPPER: nxt_ff.prdata[7:0] = cur_ff.resultFormat
                               ? {6'h00, cur_ff.result[9:8]} : cur_ff.result[9:2];
                `ADDR_RES_LOWER: nxt_ff.prdata[7:0] = cur_ff.resultFormat
                               ? cur_ff.result[7:0] : {cur_ff.result[1:0], 6'h00};
                `ADDR_COMPLETE:  nxt_ff.prdata[0] = cur_ff.complete;
                default:         nxt_ff.pslverr = 1'b1;
            endcase
        end

        // Analog routing outputs
        nxt_ff.analogCtl.analogPower    = nxt_ff.enable;
        nxt_ff.analogCtl.muxConnect     = nxt_ff.enable && channelValid(nxt_ff.channel);
        nxt_ff.analogCtl.channel        = nxt_ff.channel;
        nxt_ff.analogCtl.negRefExternal = nxt_ff.ctrl1[2];
        nxt_ff.analogCtl.posRefSelect   = nxt_ff.ctrl1[1:0];
        nxt_ff.analogCtl.sampleHold     = (nxt_ff.state == ST_CONVERT);
    end

    // State register with synchronous reset to zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // Outputs straight from flip-flops
    assign pready         = cur_ff.pready;
    assign prdata         = cur_ff.prdata;
    assign pslverr        = cur_ff.pslverr;
    assign analogCtl      = cur_ff.analogCtl;
    assign conversionBusy = cur_ff.go;
    assign completionFlag = cur_ff.complete;

endmodule : adc_sequencer_control
`default_nettype wire

//--- hw/adc_seq_defines.svh
// Constants for the converter sequencer control block.
// Assumes inclusion by bare name from the design file, the checker and the bench.
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// Register byte addresses on the APB bus
`define ADDR_CTRL0         12'h000
`define ADDR_CTRL1         12'h004
`define ADDR_TRIG          12'h008
`define ADDR_RES_UPPER     12'h00C
`define ADDR_RES_LOWER     12'h010
`define ADDR_COMPLETE      12'h014
// Field positions
`define CTRL0_ENABLE_BIT   0
`define CTRL0_GO_BIT       1
`define CTRL1_MASK         8'hF7
`define TRIG_MASK          8'h1F
`define REG_RESET          8'h00
// Channel codes
`define CH_FIXED_REF       6'h3F
`define CH_DAC             6'h3E
`define CH_TEMP            6'h3D
`define CH_GROUND          6'h3C
`define CH_PORTA_LAST      6'h05
`define CH_PORTA_HOLE      6'h03
`define CH_PORTB_FIRST     6'h0C
`define CH_PORTB_LAST      6'h0F
`define CH_PORTC_FIRST     6'h10
`define CH_PORTC_LAST      6'h17
// Conversion timing: twelve bit periods, ten of them result bits
`define CONV_PERIODS       4'hC
`define RESULT_BITS        4'hA
`define RC_DIV             7'h10
// Trigger codes
`define TRIG_NONE          5'h00
`define TRIG_LAST          5'h11

`endif

//--- hw/adc_seq_pkg.sv
// Types for the converter sequencer control block.
// Assumes no constant from the defines header; all widths are literal.
package adc_seq_pkg;
    // Analog routing toward the converter front end
    typedef struct packed {
        logic        analogPower;
        logic        muxConnect;
        logic [5:0]  channel;
        logic        negRefExternal;
        logic [1:0]  posRefSelect;
        logic        sampleHold;
    } analog_ctl_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT
    } conv_state_t;
endpackage : adc_seq_pkg

//--- sim/adc_sequencer_control_assertions.sv
// Port checker of the converter sequencer block.
// Assumes it is bound to the design top module.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"
module adc_seq_chk
    import adc_seq_pkg::*;
(
    // Clock, reset and bus
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Converter side
    input wire logic        conversionBusy,
    input wire logic        completionFlag,
    input wire analog_ctl_t analogCtl
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Handshake: exactly one wait state, one-cycle answer
    sequence accessWait;
        psel && penable && !pready;
    endsequence
    sequence answerPulse;
        pready ##1 !pready;
    endsequence
    ready_one_wait_a: assert property (accessWait |=> answerPulse)
        else $error("bus answer late or stuck");
    err_map_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > `ADDR_COMPLETE))
        else $error("slave error on wrong address");
    read_width_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data above low byte");
    trig_bits_a: assert property (
        pready && !pwrite && paddr == `ADDR_TRIG |-> prdata[7:5] == 3'h0)
        else $error("trigger select spare bits set");
    // Routing and sequencing
    mux_off_a: assert property (!analogCtl.analogPower |-> !analogCtl.muxConnect)
        else $error("mux connected while disabled");
    reserved_chan_a: assert property (
        analogCtl.muxConnect |-> !(analogCtl.channel inside {6'h03, [6'h06:6'h0B], [6'h18:6'h3B]}))
        else $error("reserved channel connected");
    busy_power_a: assert property ($rose(conversionBusy) |-> analogCtl.analogPower)
        else $error("conversion started while disabled");
    flag_clear_a: assert property (
        $fell(completionFlag) |-> pready && pwrite && paddr == `ADDR_COMPLETE)
        else $error("flag cleared without a write");
    flag_done_a: assert property ($rose(completionFlag) |-> !conversionBusy)
        else $error("flag set while still busy");
endmodule : adc_seq_chk

bind adc_sequencer_control adc_seq_chk adc_seq_chk_inst (.clk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pready, .prdata, .pslverr, .conversionBusy, .completionFlag, .analogCtl);
`default_nettype wire

//--- sim/test_adc_sequencer_control.sv
// Bench of the converter sequencer block, driven over APB.
// Assumes package, defines header and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"
module test_adc_sequencer_control
    import adc_seq_pkg::*;
;
    logic        clk = 1'h0;
    logic        sys_rst = 1'h1;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [17:0] triggerSources = 18'h0;
    logic [1:0]  rcPhase = 2'h0;
    logic        compareHigh = 1'h1;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, conversionBusy, completionFlag;
    analog_ctl_t analogCtl;
    wire         rcTickPin = rcPhase[1];
    int          err_count = 0;
    int          n_checks = 0;
    int          divs[8] = '{2, 8, 32, 2, 4, 16, 64, 2};

    // Clock; RC tick changes every two cycles
    always #25 clk = ~clk;
    always @(posedge clk) rcPhase <= rcPhase + 2'h1;

    adc_sequencer_control adc_sequencer_control_inst (.clk, .sys_rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .prdata, .pslverr, .triggerSources, .rcTickPin, .compareHigh,
        .analogCtl, .conversionBusy, .completionFlag);

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask : chk

    task automatic chkb(input string s, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %b seen %b", s, e, g);
        end
    endtask : chkb

    // One transfer; held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        // Sample the answer at the rising edge, before it updates
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            err_count++;
            $display("unexpected bus answer: expected %b seen %b", 1'h1, pready);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic wait_busy;
        for (int n = 0; n < 10 && conversionBusy !== 1'h1; n++) @(negedge clk);
    endtask : wait_busy

    function automatic logic legal(input logic [5:0] c);
        return (c <= 6'h05 && c != 6'h03) || (c >= 6'h0C && c <= 6'h17) || c >= 6'h3C;
    endfunction : legal

    // Reset values, spare bits, unmapped address
    task automatic t_regs;
        apb(1'h0, `ADDR_CTRL0, 32'h0);
        chk("ctrl0 reset", 32'h00, rd);
        apb(1'h0, `ADDR_CTRL1, 32'h0);
        chk("ctrl1 reset", 32'h00, rd);
        apb(1'h1, `ADDR_CTRL1, 32'hFF);
        apb(1'h0, `ADDR_CTRL1, 32'h0);
        chk("ctrl1 spare", 32'hF7, rd);
        apb(1'h1, `ADDR_TRIG, 32'hFF);
        apb(1'h0, `ADDR_TRIG, 32'h0);
        chk("trig spare", 32'h1F, rd);
        apb(1'h0, 12'h018, 32'h0);
        chkb("unmapped error", 1'h1, err);
    endtask : t_regs

    // Every channel code, enabled and not, with reference fields
    task automatic t_chan;
        for (int i = 0; i < 128; i++) begin
            apb(1'h1, `ADDR_CTRL1, {29'h0, i[3:1]});
            apb(1'h1, `ADDR_CTRL0, {24'h0, i[6:1], 1'h0, i[0]});
            repeat (2) @(negedge clk);
            chkb("mux connect", i[0] && legal(i[6:1]), analogCtl.muxConnect);
            chkb("power", i[0], analogCtl.analogPower);
            chk("refs", {29'h0, i[3:1]}, {29'h0, analogCtl.negRefExternal, analogCtl.posRefSelect});
        end
    endtask : t_chan

    // Trigger edges start conversions; levels, other sources and off state do not
    task automatic t_trig;
        apb(1'h1, `ADDR_CTRL1, 32'h00);
        apb(1'h1, `ADDR_CTRL0, 32'h02);
        repeat (4) @(negedge clk);
        chkb("go while off", 1'h0, conversionBusy);
        apb(1'h1, `ADDR_CTRL0, 32'h01);
        for (int k = 1; k < 18; k++) begin
            apb(1'h1, `ADDR_TRIG, 32'(k));
            triggerSources <= ~(18'h1 << k);
            repeat (6) @(negedge clk);
            chkb("other source", 1'h0, conversionBusy);
            @(posedge clk) triggerSources <= 18'h3FFFF;
            wait_busy();
            chkb("edge start", 1'h1, conversionBusy);
            repeat (80) @(negedge clk);
            chkb("level held", 1'h0, conversionBusy);
            @(posedge clk) triggerSources <= 18'h0;
        end
        apb(1'h1, `ADDR_CTRL0, 32'h00);
        triggerSources <= 18'h3FFFF;
        repeat (6) @(negedge clk);
        chkb("trigger while off", 1'h0, conversionBusy);
    endtask : t_trig

    // Software start, length per clock code, format, completion
    task automatic t_conv(input int i);
        int n;
        n = 0;
        apb(1'h1, `ADDR_CTRL1, {24'h0, i[0], i[2:0], 4'h0});
        apb(1'h1, `ADDR_CTRL0, 32'h01);
        repeat (4) @(posedge clk);
        apb(1'h1, `ADDR_CTRL0, 32'h03);
        wait_busy();
        while (conversionBusy === 1'h1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chkb("span", 1'h1, n >= 11 * divs[i] && n <= 13 * divs[i] + 8);
        apb(1'h0, `ADDR_CTRL0, 32'h0);
        chk("go done", 32'h01, rd);
        chkb("flag set", 1'h1, completionFlag);
        apb(1'h0, `ADDR_RES_UPPER, 32'h0);
        chk("upper", i[0] ? 32'h03 : 32'hFF, rd);
        apb(1'h0, `ADDR_RES_LOWER, 32'h0);
        chk("lower", i[0] ? 32'hFF : 32'hC0, rd);
        apb(1'h1, `ADDR_COMPLETE, 32'h0);
        @(negedge clk);
        chkb("flag clear", 1'h0, completionFlag);
    endtask : t_conv

    // Early stop keeps decided bits, fills the rest
    task automatic t_abort;
        apb(1'h1, `ADDR_CTRL1, 32'h60);
        apb(1'h1, `ADDR_CTRL0, 32'h01);
        compareHigh <= 1'h0;
        apb(1'h1, `ADDR_CTRL0, 32'h03);
        // Bits 9 and 8 decide low, bit 7 high, then abort fills with one
        repeat (290) @(posedge clk);
        compareHigh <= 1'h1;
        repeat (30) @(posedge clk);
        apb(1'h1, `ADDR_CTRL0, 32'h01);
        @(negedge clk);
        chkb("stopped", 1'h0, conversionBusy);
        apb(1'h0, `ADDR_RES_UPPER, 32'h0);
        chk("partial upper", 32'h3F, rd);
        apb(1'h0, `ADDR_RES_LOWER, 32'h0);
        chk("partial lower", 32'hC0, rd);
    endtask : t_abort

    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'h0;
        t_regs();
        t_chan();
        t_trig();
        for (int i = 0; i < 8; i++) t_conv(i);
        t_abort();
        complete_run();
    end

    // Watchdog well past the expected run
    initial begin
        #2000000;
        err_count++;
        complete_run();
    end
endmodule : test_adc_sequencer_control
`default_nettype wire
